//--- pkg/dac_pkg.sv
// Constants, types and state record for the dual alarm comparator.
package dac_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int TICK_PERIOD_NS = 500_000_000;
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICKS_PER_SEC  = 2;

	// ------------------------------------------------------------------
	// Widths and ranges
	// ------------------------------------------------------------------
	localparam int RATE_W  = 20;
	localparam int TOTAL_W = 27;
	localparam int SECS_W  = 12;
	localparam int TIMER_W = 13;
	localparam int CNT_W   = 32;
	localparam int CHANS   = 2;

	localparam logic [TOTAL_W-1:0] RATE_MAX   = 27'h00F423F;
	localparam logic [TOTAL_W-1:0] TOTAL_MAX  = 27'h5F5E0FF;
	localparam logic [SECS_W-1:0]  SECS_MAX   = 12'hE10;
	localparam logic [TOTAL_W-RATE_W-1:0] RATE_PAD = 7'h00;

	// ------------------------------------------------------------------
	// Selections
	// ------------------------------------------------------------------
	localparam logic FLOW_RATE_CHOICE       = 1'b0;
	localparam logic ACCUMULATED_SUM_CHOICE = 1'b1;
	localparam logic TRIP_HIGH              = 1'b0;
	localparam logic TRIP_LOW               = 1'b1;

	// ------------------------------------------------------------------
	// Channel defaults, also restored on a change of monitored quantity
	// ------------------------------------------------------------------
	localparam logic [TOTAL_W-1:0] DEFAULT_THRESHOLD = 27'h0000000;
	localparam logic [RATE_W-1:0]  DEFAULT_BAND      = 20'h00000;
	localparam logic [SECS_W-1:0]  DEFAULT_SECONDS   = 12'h000;
	localparam logic               DEFAULT_DIRECTION = 1'b0;
	localparam logic               DEFAULT_CLOSED    = 1'b0;
	localparam logic               DEFAULT_ALT       = 1'b0;

	typedef enum logic [1:0] {
		DAC_IDLE,
		DAC_DELAY,
		DAC_ACTIVE,
		DAC_SILENCED
	} dac_phase_type;

	typedef struct packed {
		logic [CHANS-1:0][TOTAL_W-1:0] threshold;
		logic [CHANS-1:0][RATE_W-1:0]  band;
		logic [CHANS-1:0][SECS_W-1:0]  delay;
		logic [CHANS-1:0][SECS_W-1:0]  silence;
		logic [CHANS-1:0]              quantity;
		logic [CHANS-1:0]              direction;
		logic [CHANS-1:0]              closed_idle;
		logic [CHANS-1:0]              alt_option;
		logic [CHANS-1:0]              enabled;
		logic [CHANS-1:0][TIMER_W-1:0] timer;
		dac_phase_type [CHANS-1:0]     phase;
		logic [CHANS-1:0]              accept_pending;
		logic [CNT_W-1:0]              tick_count;
		logic                          blink;
		logic [2:0]                    btn_sync;
		logic                          btn_level;
		logic [CHANS-1:0]              switch_closed;
		logic [CHANS-1:0]              annunciator;
		logic [CHANS-1:0]              label_show;
	} dac_state_type;

	// All defaults are zero, so the reset record is all zero.
	localparam dac_state_type DAC_RESET_STATE = '0;

endpackage : dac_pkg

//--- logic/dac_dual_alarm_comparator.sv
// Two independent rate/total alarm channels with delay and silence.
`timescale 1ns/1ps

module dac_dual_alarm_comparator #(
	parameter int TICK_CYCLES = dac_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst_b,
	// Measured values, same clock domain
	input  wire logic [dac_pkg::RATE_W-1:0]   rate_value,
	input  wire logic [dac_pkg::TOTAL_W-1:0]  total_value,
	// Channel configuration, stored on a per-channel write strobe
	input  wire logic [1:0]                   cfg_write,
	input  wire logic                         monitored_quantity_select,
	input  wire logic                         trip_direction_select,
	input  wire logic                         cfg_closed_idle,
	input  wire logic [dac_pkg::TOTAL_W-1:0]  cfg_threshold,
	input  wire logic [dac_pkg::RATE_W-1:0]   release_band,
	input  wire logic [dac_pkg::SECS_W-1:0]   activation_delay_seconds,
	input  wire logic [dac_pkg::SECS_W-1:0]   cfg_silence_seconds,
	input  wire logic                         alternating_display_option,
	// Enable, written apart from the rest of the configuration
	input  wire logic [1:0]                   enable_write,
	input  wire logic                         enable_value,
	// Front panel accept push button, asynchronous pin
	input  wire logic                         accept_button,
	// Switch drive, high closes the switch
	output logic      [1:0]                   switch_closed,
	// Display annunciators and alternating label request
	output logic      [1:0]                   annunciator_on,
	output logic      [1:0]                   label_show,
	// Status
	output logic      [1:0]                   alarm_enabled,
	output logic      [1:0]                   quantity_status
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	dac_pkg::dac_state_type state;
	dac_pkg::dac_state_type next_state;

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		logic                        tick;
		logic                        press;
		logic                        held;
		logic                        cond;
		logic [dac_pkg::TOTAL_W-1:0] value;
		logic [dac_pkg::TOTAL_W-1:0] sp;
		logic [dac_pkg::TOTAL_W-1:0] band;
		logic [dac_pkg::TOTAL_W-1:0] floor_val;
		logic [dac_pkg::TOTAL_W-1:0] lim;
		tick      = 1'b0;
		press     = 1'b0;
		held      = 1'b0;
		cond      = 1'b0;
		value     = '0;
		sp        = '0;
		band      = '0;
		floor_val = '0;
		lim       = '0;
		next_state = state;

		// Half-second compare tick, independent of any display rate.
		tick = (state.tick_count == dac_pkg::CNT_W'(TICK_CYCLES - 1));
		if (tick) begin
			next_state.tick_count = '0;
			next_state.blink      = ~state.blink;
		end else begin
			next_state.tick_count = state.tick_count + 32'h00000001;
		end

		// The first stage only feeds the second; a change is taken once
		// the second and third stages agree, which rejects one-cycle
		// glitches at the cost of two cycles of latency.
		next_state.btn_sync = {state.btn_sync[1:0], accept_button};
		if ((state.btn_sync[1] == state.btn_sync[2]) &&
		    (state.btn_level != state.btn_sync[2])) begin
			next_state.btn_level = state.btn_sync[2];
			press                = state.btn_sync[2];
		end

		for (int ch = 0; ch < dac_pkg::CHANS; ch++) begin
			// Comparison on the tick, using the stored settings.
			if (state.quantity[ch] == dac_pkg::ACCUMULATED_SUM_CHOICE) begin
				value = total_value;
			end else begin
				value = {dac_pkg::RATE_PAD, rate_value};
			end
			sp        = state.threshold[ch];
			band      = {dac_pkg::RATE_PAD, state.band[ch]};
			held      = (state.phase[ch] != dac_pkg::DAC_IDLE);
			floor_val = (band > sp) ? '0 : sp - band;
			if (state.direction[ch] == dac_pkg::TRIP_LOW) begin
				cond = (value <= sp);
			end else if (held && (state.quantity[ch] ==
			             dac_pkg::FLOW_RATE_CHOICE)) begin
				cond = (value >= floor_val);
			end else begin
				cond = (value >= sp);
			end

			if (!state.enabled[ch]) begin
				next_state.phase[ch] = dac_pkg::DAC_IDLE;
			end else if (tick) begin
				case (state.phase[ch])
					dac_pkg::DAC_IDLE: begin
						if (cond && (state.delay[ch] == '0)) begin
							next_state.phase[ch] = dac_pkg::DAC_ACTIVE;
						end else if (cond) begin
							next_state.phase[ch] = dac_pkg::DAC_DELAY;
							next_state.timer[ch] =
								dac_pkg::TIMER_W'(state.delay[ch]) *
								dac_pkg::TIMER_W'(dac_pkg::TICKS_PER_SEC);
						end
					end
					dac_pkg::DAC_DELAY: begin
						if (!cond) begin
							next_state.phase[ch] = dac_pkg::DAC_IDLE;
						end else if (state.timer[ch] <= 13'h0001) begin
							next_state.phase[ch] = dac_pkg::DAC_ACTIVE;
						end else begin
							next_state.timer[ch] = state.timer[ch] - 13'h0001;
						end
					end
					dac_pkg::DAC_ACTIVE: begin
						if (!cond) begin
							next_state.phase[ch] = dac_pkg::DAC_IDLE;
						end else if (state.accept_pending[ch] &&
						             (state.silence[ch] != '0)) begin
							next_state.phase[ch] = dac_pkg::DAC_SILENCED;
							next_state.timer[ch] =
								dac_pkg::TIMER_W'(state.silence[ch]) *
								dac_pkg::TIMER_W'(dac_pkg::TICKS_PER_SEC);
						end
					end
					default: begin
						if (!cond) begin
							next_state.phase[ch] = dac_pkg::DAC_IDLE;
						end else if (state.timer[ch] <= 13'h0001) begin
							next_state.phase[ch] = dac_pkg::DAC_ACTIVE;
						end else begin
							next_state.timer[ch] = state.timer[ch] - 13'h0001;
						end
					end
				endcase
			end

			// Accept is held until the next tick; a press in the tick
			// cycle itself wins over the clear so it is not lost.
			if (tick) begin
				next_state.accept_pending[ch] = 1'b0;
			end
			if (press && (state.silence[ch] != '0)) begin
				next_state.accept_pending[ch] = 1'b1;
			end

			if (enable_write[ch]) begin
				next_state.enabled[ch] = enable_value;
			end

			// Configuration write; a new quantity stores nothing else.
			if (cfg_write[ch] &&
			    (monitored_quantity_select != state.quantity[ch])) begin
				next_state.quantity[ch]    = monitored_quantity_select;
				next_state.threshold[ch]   = dac_pkg::DEFAULT_THRESHOLD;
				next_state.band[ch]        = dac_pkg::DEFAULT_BAND;
				next_state.delay[ch]       = dac_pkg::DEFAULT_SECONDS;
				next_state.silence[ch]     = dac_pkg::DEFAULT_SECONDS;
				next_state.direction[ch]   = dac_pkg::DEFAULT_DIRECTION;
				next_state.closed_idle[ch] = dac_pkg::DEFAULT_CLOSED;
				next_state.alt_option[ch]  = dac_pkg::DEFAULT_ALT;
				next_state.enabled[ch]     = 1'b0;
				next_state.phase[ch]       = dac_pkg::DAC_IDLE;
				next_state.accept_pending[ch] = 1'b0;
			end else if (cfg_write[ch]) begin
				lim = (state.quantity[ch] == dac_pkg::FLOW_RATE_CHOICE) ?
					dac_pkg::RATE_MAX : dac_pkg::TOTAL_MAX;
				next_state.threshold[ch] = (cfg_threshold > lim) ?
					lim : cfg_threshold;
				next_state.band[ch] = (state.quantity[ch] ==
					dac_pkg::FLOW_RATE_CHOICE) ?
					release_band : dac_pkg::DEFAULT_BAND;
				next_state.delay[ch] =
					(activation_delay_seconds > dac_pkg::SECS_MAX) ?
					dac_pkg::SECS_MAX : activation_delay_seconds;
				next_state.silence[ch] =
					(cfg_silence_seconds > dac_pkg::SECS_MAX) ?
					dac_pkg::SECS_MAX : cfg_silence_seconds;
				next_state.direction[ch]   = trip_direction_select;
				next_state.closed_idle[ch] = cfg_closed_idle;
				next_state.alt_option[ch]  = alternating_display_option;
			end

			// A cleared enable idles the channel in the same cycle, so the
			// annunciator and label never outlive the enable flag; the switch takes its idle position.
			if (!next_state.enabled[ch]) begin
				next_state.phase[ch] = dac_pkg::DAC_IDLE;
			end

			// Registered outputs follow the next phase so they line up
			// with it in the same cycle.
			next_state.switch_closed[ch] =
				(next_state.phase[ch] == dac_pkg::DAC_ACTIVE) ^
				next_state.closed_idle[ch];
			if (next_state.phase[ch] == dac_pkg::DAC_ACTIVE) begin
				next_state.annunciator[ch] = 1'b1;
			end else if (next_state.phase[ch] == dac_pkg::DAC_IDLE) begin
				next_state.annunciator[ch] = 1'b0;
			end else begin
				next_state.annunciator[ch] = next_state.blink;
			end
			next_state.label_show[ch] = next_state.alt_option[ch] &&
				(next_state.phase[ch] == dac_pkg::DAC_ACTIVE) &&
				next_state.blink;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= dac_pkg::DAC_RESET_STATE;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign switch_closed   = state.switch_closed;
	assign annunciator_on  = state.annunciator;
	assign label_show      = state.label_show;
	assign alarm_enabled   = state.enabled;
	assign quantity_status = state.quantity;

endmodule : dac_dual_alarm_comparator

//--- test/dac_monitor.sv
// Port-level concurrent checks for the dual alarm comparator.
`timescale 1ns/1ps
module dac_monitor #(
	parameter int TICK_CYCLES = dac_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst_b,
	// Configuration strobes
	input wire logic [1:0] cfg_write,
	input wire logic       monitored_quantity_select,
	input wire logic [1:0] enable_write,
	input wire logic       enable_value,
	// Watched outputs
	input wire logic [1:0] annunciator_on,
	input wire logic [1:0] label_show,
	input wire logic [1:0] alarm_enabled,
	input wire logic [1:0] quantity_status
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_qchange0;
		cfg_write[0] && (monitored_quantity_select != quantity_status[0]);
	endsequence
	sequence s_idle0;
		!annunciator_on[0] && !label_show[0];
	endsequence

	property p_qchange0;
		s_qchange0 |=> !alarm_enabled[0] &&
			quantity_status[0] == $past(monitored_quantity_select);
	endproperty
	a_qchange0: assert property (p_qchange0)
		else $error("quantity change kept enable");
	property p_qsel1;
		cfg_write[1] |=> quantity_status[1] == $past(monitored_quantity_select);
	endproperty
	a_qsel1: assert property (p_qsel1)
		else $error("quantity select not stored");
	property p_en0;
		enable_write[0] && !cfg_write[0] |=> alarm_enabled[0] == $past(enable_value);
	endproperty
	a_en0: assert property (p_en0)
		else $error("enable write lost on channel 0");
	property p_en1;
		enable_write[1] && !cfg_write[1] |=> alarm_enabled[1] == $past(enable_value);
	endproperty
	a_en1: assert property (p_en1)
		else $error("enable write lost on channel 1");
	property p_label0;
		label_show[0] |-> annunciator_on[0] && alarm_enabled[0];
	endproperty
	a_label0: assert property (p_label0)
		else $error("label shown without active output");
	property p_off0;
		!alarm_enabled[0] [*3] |-> s_idle0;
	endproperty
	a_off0: assert property (p_off0)
		else $error("disabled channel 0 still signalling");
	property p_off1;
		$fell(alarm_enabled[1]) |-> ##[0:3] (!annunciator_on[1] && !label_show[1]);
	endproperty
	a_off1: assert property (p_off1)
		else $error("disabled channel 1 still signalling");
	// While enabled, the annunciator moves only on the compare tick, so this needs TICK_CYCLES >= 9.
	property p_blink0;
		$changed(annunciator_on[0]) && alarm_enabled[0] |=>
			$stable(annunciator_on[0]) [*8];
	endproperty
	a_blink0: assert property (p_blink0)
		else $error("annunciator moved between ticks");
endmodule : dac_monitor

bind dac_dual_alarm_comparator dac_monitor #(
	.TICK_CYCLES(TICK_CYCLES)
) dac_monitor_inst (
	.clk                       (clk),
	.rst_b                     (rst_b),
	.cfg_write                 (cfg_write),
	.monitored_quantity_select (monitored_quantity_select),
	.enable_write              (enable_write),
	.enable_value              (enable_value),
	.annunciator_on            (annunciator_on),
	.label_show                (label_show),
	.alarm_enabled             (alarm_enabled),
	.quantity_status           (quantity_status)
);

//--- test/dac_switch_load.sv
// Behavioural sounder wired through one alarm switch.
`timescale 1ns/1ps
module dac_switch_load (
	// Switch state from the comparator
	input  wire logic closed,
	// Sounder current
	output logic      sounding
);
	// The switch is not polarised; closure alone decides whether current flows.
	assign sounding = closed;
endmodule : dac_switch_load

//--- test/tb.sv
// Self-checking bench for the dual alarm comparator.
`timescale 1ns/1ps
module tb;
	localparam int TC = 20;
	logic                        clk, rst_b, a;
	logic [dac_pkg::RATE_W-1:0]  rate_value, release_band;
	logic [dac_pkg::TOTAL_W-1:0] total_value, cfg_threshold;
	logic [dac_pkg::SECS_W-1:0]  activation_delay_seconds, cfg_silence_seconds;
	logic [1:0]                  cfg_write, enable_write, switch_closed;
	logic [1:0]                  annunciator_on, label_show, alarm_enabled;
	logic [1:0]                  quantity_status, sounding;
	logic                        monitored_quantity_select, trip_direction_select;
	logic                        cfg_closed_idle, alternating_display_option;
	logic                        enable_value, accept_button;
	int                          fails, checked, cyc;

	dac_dual_alarm_comparator #(
		.TICK_CYCLES(TC)
	) dac_dual_alarm_comparator_inst (
		.clk                        (clk),
		.rst_b                      (rst_b),
		.rate_value                 (rate_value),
		.total_value                (total_value),
		.cfg_write                  (cfg_write),
		.monitored_quantity_select  (monitored_quantity_select),
		.trip_direction_select      (trip_direction_select),
		.cfg_closed_idle            (cfg_closed_idle),
		.cfg_threshold              (cfg_threshold),
		.release_band               (release_band),
		.activation_delay_seconds   (activation_delay_seconds),
		.cfg_silence_seconds        (cfg_silence_seconds),
		.alternating_display_option (alternating_display_option),
		.enable_write               (enable_write),
		.enable_value               (enable_value),
		.accept_button              (accept_button),
		.switch_closed              (switch_closed),
		.annunciator_on             (annunciator_on),
		.label_show                 (label_show),
		.alarm_enabled              (alarm_enabled),
		.quantity_status            (quantity_status)
	);
	dac_switch_load dac_switch_load_inst0 (
		.closed   (switch_closed[0]),
		.sounding (sounding[0])
	);
	dac_switch_load dac_switch_load_inst1 (
		.closed   (switch_closed[1]),
		.sounding (sounding[1])
	);

	// ------------------------------------------------------------------
	// Clock, cycle count and timeout
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= rst_b ? cyc + 1 : 0;
		if (cyc > 3000) begin
			fails++;
			stop_test();
		end
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task step;
		@(posedge clk);
		#1;
	endtask : step
	// Lands mid-way between compare ticks, n tick boundaries later.
	task mid(input int n);
		repeat (n) do step(); while (cyc % TC != 10);
	endtask : mid
	task cfg(input int ch, input logic q, dir, nc, input logic [26:0] thr,
			input logic [19:0] bd, input logic [11:0] dly, sil, input logic alt);
		monitored_quantity_select = q;
		trip_direction_select = dir;
		cfg_closed_idle = nc;
		cfg_threshold = thr;
		release_band = bd;
		activation_delay_seconds = dly;
		cfg_silence_seconds = sil;
		alternating_display_option = alt;
		cfg_write = 2'h1 << ch;
		step();
		cfg_write = 2'h0;
		step();
	endtask : cfg
	task en(input int ch, input logic v);
		enable_value = v;
		enable_write = 2'h1 << ch;
		step();
		enable_write = 2'h0;
		repeat (3) step();
	endtask : en
	task press;
		accept_button = 1'b1;
		repeat (5) step();
		accept_button = 1'b0;
	endtask : press

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task t_hyst;
		cfg(0, 1'b0, 1'b0, 1'b0, 27'h0000FA0, 20'h00064, 12'h000, 12'h000,
			1'b0);
		en(0, 1'b1);
		rate_value = 20'h00F9F;
		mid(2);
		chk(switch_closed[0], 1'b0);
		rate_value = 20'h00FA0;
		mid(2);
		chk(sounding[0], 1'b1);
		chk(annunciator_on[0], 1'b1);
		rate_value = 20'h00F3C;
		mid(2);
		chk(switch_closed[0], 1'b1);
		rate_value = 20'h00F3B;
		mid(2);
		chk(switch_closed[0], 1'b0);
	endtask : t_hyst
	task t_low_nc;
		cfg(1, 1'b1, 1'b0, 1'b0, 27'h0, 20'h0, 12'h000, 12'h000, 1'b0);
		chk(alarm_enabled, 2'h1);
		cfg(1, 1'b1, 1'b1, 1'b1, 27'h00001F4, 20'h0, 12'h000, 12'h000, 1'b0);
		en(1, 1'b1);
		total_value = 27'h00001F5;
		mid(2);
		chk(switch_closed, 2'h2);
		total_value = 27'h00001F4;
		mid(2);
		chk(sounding[1], 1'b0);
		press();
		mid(2);
		chk(switch_closed[1], 1'b0);
		chk(switch_closed[0], 1'b0);
		en(1, 1'b0);
		chk(annunciator_on[1], 1'b0);
	endtask : t_low_nc
	task t_delay_silence;
		rate_value = 20'h0;
		cfg(0, 1'b0, 1'b0, 1'b0, 27'h000000A, 20'h0, 12'h001, 12'h001, 1'b1);
		mid(1);
		rate_value = 20'h0000A;
		mid(1);
		chk(switch_closed[0], 1'b0);
		a = annunciator_on[0];
		mid(1);
		chk(annunciator_on[0], !a);
		mid(1);
		chk(switch_closed[0], 1'b1);
		chk(annunciator_on[0], 1'b1);
		a = label_show[0];
		mid(1);
		chk(label_show[0], !a);
		press();
		mid(1);
		chk(switch_closed[0], 1'b0);
		a = annunciator_on[0];
		mid(1);
		chk(annunciator_on[0], !a);
		mid(1);
		chk(switch_closed[0], 1'b1);
		en(0, 1'b0);
		chk(switch_closed[0], 1'b0);
		en(0, 1'b1);
		mid(4);
		chk(switch_closed[0], 1'b1);
		rate_value = 20'h0;
		mid(2);
		chk(annunciator_on[0], 1'b0);
	endtask : t_delay_silence
	task t_quantity;
		total_value = dac_pkg::TOTAL_MAX;
		cfg(0, 1'b1, 1'b1, 1'b1, 27'h0000005, 20'h5, 12'h005, 12'h005, 1'b0);
		chk(quantity_status, 2'h3);
		en(0, 1'b1);
		mid(2);
		chk(switch_closed[0], 1'b1);
		cfg(0, 1'b1, 1'b0, 1'b0, 27'h7FFFFFF, 20'h0, 12'h000, 12'h000, 1'b0);
		mid(2);
		chk(switch_closed[0], 1'b1);
		total_value = dac_pkg::TOTAL_MAX - 27'h1;
		mid(2);
		chk(switch_closed[0], 1'b0);
	endtask : t_quantity

	task stop_test;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	initial begin
		{rst_b, rate_value, total_value, cfg_threshold, release_band} = '0;
		{activation_delay_seconds, cfg_silence_seconds, cfg_write} = '0;
		{enable_write, monitored_quantity_select, trip_direction_select} = '0;
		{cfg_closed_idle, alternating_display_option, enable_value} = '0;
		accept_button = 1'b0;
		repeat (10) @(posedge clk);
		#1 rst_b = 1'b1;
		mid(1);
		chk({switch_closed, annunciator_on, alarm_enabled}, 6'h00);
		t_hyst();
		t_low_nc();
		t_delay_silence();
		t_quantity();
		stop_test();
	end
endmodule : tb
